// File: core/eeprom_program_erase_ctrl.sv
// Behaviour
// - Erased bits read one; programming clears bits, erasing sets them back.
// - Only unprotected array bytes and the nonvolatile register are ever altered.
// - Erase-select picks program, byte, block or bulk erase; protection forbids all.
// - With latching on, valid array writes capture address and data, newest wins.
// - With latching on, array reads return the captured data.
// - With latching on, control writes are ignored until a valid array or config write.
// - High voltage cannot be enabled without latching and a captured write.
// - High-voltage enable drives the pump when armed; clearing stops it; reset clears.
// - Latch enable cannot clear while high voltage is enabled; reset clears it.
// - Clearing both bits in one write clears only high voltage.
// - Erase select is frozen while high voltage is enabled.
// - Block erase sets every bit of the latched block, bulk the array, never the config.
// - Four 128-byte blocks in ascending order, each with its own protect bit.
// - No voltage for protected targets; bulk erase barred if any block protected.
// - Reset and each config read copy nonvolatile into volatile configuration.
// - Security blocks top sixteen bytes, block, bulk and config changes.
// - With security on, writes to secured bytes are not valid captures.
// - Security is permanent and freezes the nonvolatile configuration.
// - Pump clock select: one picks bus clock, zero the RC oscillator.
// - Power-down disables the array and needs a recovery time when cleared.
// - Stop mode removes the voltage but keeps the enable; it returns afterwards.
`include "eeprom_ctrl_params.svh"
`timescale 1ns/1ns
`default_nettype none

module eeprom_program_erase_ctrl #(
    parameter logic [15:0] PROGRAM_CYCLES = 16'(`EE_PROGRAM_CYC),
    parameter logic [15:0] BLOCK_CYCLES = 16'(`EE_BLOCK_CYC),
    parameter logic [15:0] BULK_CYCLES = 16'(`EE_BULK_CYC),
    parameter logic [15:0] RECOVERY_CYCLES = 16'(`EE_RECOVERY_CYC)
) (
    input wire logic core_clk, // Bus clock, 25 MHz.
    input wire logic srst, // Synchronous reset, active high.
    input wire logic psel, // APB select.
    input wire logic penable, // APB access phase.
    input wire logic pwrite, // APB direction, high for write.
    input wire logic [11:0] paddr, // APB byte address.
    input wire logic [31:0] pwdata, // APB write data.
    output logic [31:0] prdata, // APB read data.
    output logic pready, // APB ready.
    output logic pslverr, // APB error for unmapped address.
    input wire logic stop_mode, // Asynchronous stop-mode request.
    output logic pump_on, // Programming voltage applied.
    output logic pump_clk_bus, // Pump clocked from bus clock when high.
    output logic array_off // Array powered down.
);

    eeprom_ctrl_pkg::array_control_t ctrl_reg, ctrl_next;
    eeprom_ctrl_pkg::nv_config_t nv_cfg_reg = eeprom_ctrl_pkg::nv_config_t'(`EE_NV_FACTORY);
    eeprom_ctrl_pkg::nv_config_t vcfg_reg;
    eeprom_ctrl_pkg::capture_t cap_reg;
    eeprom_ctrl_pkg::pwr_state_t pwr_reg, pwr_next;
    eeprom_ctrl_pkg::op_mode_t mode;
    eeprom_ctrl_pkg::status_t status;
    logic [7:0] mem_reg [`EE_ARRAY_BYTES] = '{default: `EE_ERASED_BYTE};
    logic captured_reg;
    logic done_reg;
    logic pump_reg;
    logic stop_meta_reg, stop_sync_reg;
    logic pready_reg;
    logic pslverr_reg;
    logic [31:0] prdata_reg;
    logic [15:0] op_cnt_reg;
    logic [15:0] rec_cnt_reg, rec_cnt_next;

    // Bus phase qualifiers.
    wire setup_ph = psel & ~penable & ~pready_reg;
    wire access = psel & penable & pready_reg;
    wire acc_wr = access & pwrite;
    wire acc_rd = access & ~pwrite;

    // Address decode.
    wire sel_array = paddr <= `EE_ARRAY_TOP;
    wire sel_ctrl = {paddr[11:2], 2'b00} == `EE_CTRL_ADDR;
    wire sel_nv = {paddr[11:2], 2'b00} == `EE_NVCFG_ADDR;
    wire sel_vcfg = {paddr[11:2], 2'b00} == `EE_VCFG_ADDR;
    wire sel_status = {paddr[11:2], 2'b00} == `EE_STATUS_ADDR;
    wire sel_mapped = sel_array | sel_ctrl | sel_nv | sel_vcfg | sel_status;
    wire [8:0] bus_index = paddr[10:2];

    // Security is read from the nonvolatile copy so it cannot be undone by reset.
    wire secure_on = ~nv_cfg_reg.security_arm_n;
    wire bus_secured = bus_index >= `EE_SECURE_BASE;
    wire cap_secured = cap_reg.index >= `EE_SECURE_BASE;

    // A valid target write: any array byte, less the secured range while security is on, or the config byte.
    wire valid_tgt = (sel_array & ~(secure_on & bus_secured)) | sel_nv;
    wire capture_now = acc_wr & ctrl_reg.latch_enable & valid_tgt;

    // Control writes are dropped while a latch waits for its target.
    wire ctrl_blocked = ctrl_reg.latch_enable & ~captured_reg;
    wire ctrl_wr = acc_wr & sel_ctrl & ~ctrl_blocked;
    eeprom_ctrl_pkg::array_control_t wr_val;
    assign wr_val = eeprom_ctrl_pkg::array_control_t'(pwdata[7:0]);

    // Operation selected and whether the captured target may receive voltage.
    assign mode = eeprom_ctrl_pkg::op_mode_t'({ctrl_reg.erase_select_hi, ctrl_reg.erase_select_lo});
    wire blk_prot = vcfg_reg.block_protect[cap_reg.index[8:7]];
    wire any_prot = |vcfg_reg.block_protect;
    wire byte_mode = (mode == eeprom_ctrl_pkg::OP_PROGRAM) | (mode == eeprom_ctrl_pkg::OP_BYTE_ERASE);
    wire nv_ok = byte_mode & ~secure_on;
    wire byte_ok = byte_mode & ~blk_prot & ~(secure_on & cap_secured);
    wire block_ok = (mode == eeprom_ctrl_pkg::OP_BLOCK_ERASE) & ~blk_prot & ~secure_on;
    wire bulk_ok = (mode == eeprom_ctrl_pkg::OP_BULK_ERASE) & ~any_prot & ~secure_on;
    wire op_allowed = captured_reg & (cap_reg.is_nv ? nv_ok : (byte_ok | block_ok | bulk_ok));

    // Voltage is applied only when enabled, armed, allowed and not in stop mode.
    wire pump_next = ctrl_reg.high_voltage_enable & ctrl_reg.latch_enable & op_allowed
        & ~stop_sync_reg;

    // Pulse length for the selected operation; byte erase uses the program time.
    wire [15:0] op_len = (mode == eeprom_ctrl_pkg::OP_BLOCK_ERASE) ? BLOCK_CYCLES :
                         (mode == eeprom_ctrl_pkg::OP_BULK_ERASE) ? BULK_CYCLES : PROGRAM_CYCLES;
    wire op_fire = pump_reg & ~done_reg & (op_cnt_reg + `EE_COUNT_ONE >= op_len);

    // Next control value. High voltage only sets when latching and a capture exist.
    always_comb begin
        ctrl_next = ctrl_reg;
        if (ctrl_wr) begin
            ctrl_next.pump_clock_select = wr_val.pump_clock_select;
            ctrl_next.array_power_down = wr_val.array_power_down;
            ctrl_next.high_voltage_enable = wr_val.high_voltage_enable
                & ctrl_reg.latch_enable & captured_reg;
            ctrl_next.latch_enable = wr_val.latch_enable | ctrl_reg.high_voltage_enable;
            if (!ctrl_reg.high_voltage_enable) begin
                ctrl_next.erase_select_hi = wr_val.erase_select_hi;
                ctrl_next.erase_select_lo = wr_val.erase_select_lo;
            end
        end
        ctrl_next.reserved = 2'b00;
    end

    // Control register.
    always_ff @(posedge core_clk) begin
        if (srst) begin
            ctrl_reg <= eeprom_ctrl_pkg::array_control_t'(`EE_CTRL_RESET);
        end else begin
            ctrl_reg <= ctrl_next;
        end
    end

    // Capture of target address and data; cleared whenever latching drops.
    always_ff @(posedge core_clk) begin
        if (srst) begin
            captured_reg <= 1'b0;
            cap_reg <= '0;
        end else if (!ctrl_reg.latch_enable) begin
            captured_reg <= 1'b0;
        end else if (capture_now) begin
            captured_reg <= 1'b1;
            cap_reg <= {sel_nv, bus_index, pwdata[7:0]};
        end
    end

    // Stop request crosses in from outside on two flops.
    always_ff @(posedge core_clk) begin
        if (srst) begin
            stop_meta_reg <= 1'b0;
            stop_sync_reg <= 1'b0;
        end else begin
            stop_meta_reg <= stop_mode;
            stop_sync_reg <= stop_meta_reg;
        end
    end

    // Pump drive and pulse timing. The count pauses in stop mode, so an
    // interrupted pulse is stretched rather than cut short.
    always_ff @(posedge core_clk) begin
        if (srst) begin
            pump_reg <= 1'b0;
            done_reg <= 1'b0;
            op_cnt_reg <= `EE_COUNT_ZERO;
        end else begin
            pump_reg <= pump_next;
            if (!ctrl_reg.high_voltage_enable) begin
                done_reg <= 1'b0;
                op_cnt_reg <= `EE_COUNT_ZERO;
            end else if (op_fire) begin
                done_reg <= 1'b1;
            end else if (pump_reg && !done_reg) begin
                op_cnt_reg <= op_cnt_reg + `EE_COUNT_ONE;
            end
        end
    end

    // Array cells. Program can only clear bits, erase only set them.
    generate
        for (genvar gi = 0; gi < `EE_ARRAY_BYTES; gi++) begin : g_cell
            localparam logic [8:0] IDX = 9'(gi);
            wire hit_byte = byte_mode & (cap_reg.index == IDX);
            wire hit_block = (mode == eeprom_ctrl_pkg::OP_BLOCK_ERASE) & (cap_reg.index[8:7] == IDX[8:7]);
            wire hit_bulk = mode == eeprom_ctrl_pkg::OP_BULK_ERASE;
            wire hit = op_fire & ~cap_reg.is_nv & (hit_byte | hit_block | hit_bulk);
            always_ff @(posedge core_clk) begin
                if (hit) begin
                    mem_reg[gi] <= (mode == eeprom_ctrl_pkg::OP_PROGRAM) ?
                        (mem_reg[gi] & cap_reg.data) : `EE_ERASED_BYTE;
                end
            end
        end
    endgenerate

    // Nonvolatile configuration. Not reset: it survives like the array.
    // Once security is armed no operation on it is allowed, which freezes it.
    always_ff @(posedge core_clk) begin
        if (op_fire && cap_reg.is_nv) begin
            nv_cfg_reg <= (mode == eeprom_ctrl_pkg::OP_PROGRAM) ?
                (nv_cfg_reg & eeprom_ctrl_pkg::nv_config_t'(cap_reg.data)) :
                eeprom_ctrl_pkg::nv_config_t'(`EE_ERASED_BYTE);
        end
    end

    // Volatile copy, reloaded at reset and on every read of the config byte.
    always_ff @(posedge core_clk) begin
        if (srst || (acc_rd && sel_nv)) begin
            vcfg_reg <= nv_cfg_reg;
        end
    end

    // Power-down sequencing with the recovery wait after it clears.
    always_comb begin
        pwr_next = pwr_reg;
        rec_cnt_next = rec_cnt_reg;
        case (pwr_reg)
            eeprom_ctrl_pkg::PWR_ON: begin
                if (ctrl_reg.array_power_down) begin
                    pwr_next = eeprom_ctrl_pkg::PWR_OFF;
                end
            end
            eeprom_ctrl_pkg::PWR_OFF: begin
                if (!ctrl_reg.array_power_down) begin
                    pwr_next = eeprom_ctrl_pkg::PWR_RECOVER;
                    rec_cnt_next = `EE_COUNT_ZERO;
                end
            end
            default: begin
                if (ctrl_reg.array_power_down) begin
                    pwr_next = eeprom_ctrl_pkg::PWR_OFF;
                end else if (rec_cnt_reg + `EE_COUNT_ONE >= RECOVERY_CYCLES) begin
                    pwr_next = eeprom_ctrl_pkg::PWR_ON;
                end else begin
                    rec_cnt_next = rec_cnt_reg + `EE_COUNT_ONE;
                end
            end
        endcase
    end

    // Power state registers.
    always_ff @(posedge core_clk) begin
        if (srst) begin
            pwr_reg <= eeprom_ctrl_pkg::PWR_ON;
            rec_cnt_reg <= `EE_COUNT_ZERO;
        end else begin
            pwr_reg <= pwr_next;
            rec_cnt_reg <= rec_cnt_next;
        end
    end

    // Read data. With latching off, a disabled or recovering array reads zero, as its content is not defined then.
    wire array_ready = pwr_reg == eeprom_ctrl_pkg::PWR_ON;
    wire [7:0] array_rd = ctrl_reg.latch_enable ? cap_reg.data :
                          array_ready ? mem_reg[bus_index] : `EE_ZERO_BYTE;
    assign status = {pwr_reg != eeprom_ctrl_pkg::PWR_ON, done_reg, captured_reg, pump_reg};
    wire [31:0] rd_word = sel_array ? {`EE_ZERO_PAD, array_rd} :
                          sel_ctrl ? {`EE_ZERO_PAD, ctrl_reg} :
                          sel_nv ? {`EE_ZERO_PAD, nv_cfg_reg} :
                          sel_vcfg ? {`EE_ZERO_PAD, vcfg_reg} :
                          sel_status ? {`EE_STATUS_PAD, status} : 32'h00000000;

    // APB answer: ready rises on the first access cycle, so every transfer takes two cycles.
    always_ff @(posedge core_clk) begin
        if (srst) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h00000000;
        end else begin
            pready_reg <= setup_ph;
            pslverr_reg <= setup_ph & ~sel_mapped;
            if (setup_ph && !pwrite) begin
                prdata_reg <= rd_word;
            end
        end
    end

    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign prdata = prdata_reg;
    assign pump_on = pump_reg;
    assign pump_clk_bus = ctrl_reg.pump_clock_select;
    assign array_off = ctrl_reg.array_power_down;

endmodule : eeprom_program_erase_ctrl

`default_nettype wire

// File: core/eeprom_ctrl_params.svh
`ifndef EEPROM_CTRL_PARAMS_SVH
`define EEPROM_CTRL_PARAMS_SVH

// Register byte addresses on the 12-bit APB window.
`define EE_ARRAY_TOP 12'h7FF
`define EE_CTRL_ADDR 12'h800
`define EE_NVCFG_ADDR 12'h804
`define EE_VCFG_ADDR 12'h808
`define EE_STATUS_ADDR 12'h80C

// Array geometry.
`define EE_ARRAY_BYTES 512
`define EE_SECURE_BASE 9'h1F0
`define EE_ERASED_BYTE 8'hFF
`define EE_ZERO_BYTE 8'h00
`define EE_ZERO_PAD 24'h000000
`define EE_STATUS_PAD 28'h0000000
`define EE_CTRL_RESET 8'h00
`define EE_NV_FACTORY 8'h10

// Timing figures in microseconds, and the bus clock in MHz.
`define EE_CLK_MHZ 25
`define EE_PROGRAM_US 10
`define EE_BLOCK_US 20
`define EE_BULK_US 40
`define EE_RECOVERY_US 10

// Cycle counts derived from the figures above.
`define EE_PROGRAM_CYC (`EE_PROGRAM_US * `EE_CLK_MHZ)
`define EE_BLOCK_CYC (`EE_BLOCK_US * `EE_CLK_MHZ)
`define EE_BULK_CYC (`EE_BULK_US * `EE_CLK_MHZ)
`define EE_RECOVERY_CYC (`EE_RECOVERY_US * `EE_CLK_MHZ)
`define EE_COUNT_ONE 16'h0001
`define EE_COUNT_ZERO 16'h0000

`endif

// File: core/eeprom_ctrl_pkg.sv
package eeprom_ctrl_pkg;

    // Operation chosen by the two erase-select bits, in their binary order.
    typedef enum logic [1:0] {
        OP_PROGRAM,
        OP_BYTE_ERASE,
        OP_BLOCK_ERASE,
        OP_BULK_ERASE
    } op_mode_t;

    // Array power sequencing.
    typedef enum logic [1:0] {
        PWR_ON,
        PWR_OFF,
        PWR_RECOVER
    } pwr_state_t;

    // Control register layout, bit 7 first.
    typedef struct packed {
        logic pump_clock_select;
        logic array_power_down;
        logic erase_select_hi;
        logic erase_select_lo;
        logic [1:0] reserved;
        logic latch_enable;
        logic high_voltage_enable;
    } array_control_t;

    // Nonvolatile and volatile configuration layout, bit 7 first.
    typedef struct packed {
        logic reserved;
        logic [1:0] config_bits;
        logic security_arm_n;
        logic [3:0] block_protect;
    } nv_config_t;

    // Captured target of a program or erase.
    typedef struct packed {
        logic is_nv;
        logic [8:0] index;
        logic [7:0] data;
    } capture_t;

    // Status register layout, bit 3 first.
    typedef struct packed {
        logic recovering;
        logic op_done;
        logic captured;
        logic pump_active;
    } status_t;

endpackage : eeprom_ctrl_pkg

// File: tb/ee_ctrl_props.sv
`include "eeprom_ctrl_params.svh"
`timescale 1ns/1ns
`default_nettype none

module ee_ctrl_props (
    input wire logic core_clk, // Bus clock.
    input wire logic srst, // Synchronous reset.
    input wire logic psel, // APB select.
    input wire logic penable, // APB access phase.
    input wire logic pwrite, // APB direction.
    input wire logic [11:0] paddr, // APB address.
    input wire logic [31:0] pwdata, // APB write data.
    input wire logic [31:0] prdata, // APB read data.
    input wire logic pready, // APB ready.
    input wire logic pslverr, // APB error.
    input wire logic stop_mode, // Stop request.
    input wire logic pump_on, // Voltage applied.
    input wire logic pump_clk_bus, // Pump clock source.
    input wire logic array_off // Array power-down.
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (srst);

    // A completed control write, or reset, is the only lawful cause of a control pin change.
    logic wr_ctrl;
    assign wr_ctrl = psel && penable && pready && pwrite && (paddr == `EE_CTRL_ADDR);

    // The two steps of a transfer as seen at the slave.
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_done;
        psel && penable && pready;
    endsequence

    a_ready_after_setup: assert property (s_setup |=> pready) else $error("no ready after setup");
    a_ready_one_cycle: assert property (pready |=> !pready) else $error("ready held too long");
    a_err_with_ready: assert property (pslverr |-> pready) else $error("error without ready");
    a_err_unmapped: assert property (s_done ##0 (paddr > `EE_STATUS_ADDR) |-> pslverr)
        else $error("unmapped access not refused");
    a_upper_zero: assert property (s_done ##0 !pwrite |-> prdata[31:8] == 24'h000000)
        else $error("upper read bits not zero");
    a_ctrl_resv_zero: assert property (s_done ##0 (!pwrite && paddr == `EE_CTRL_ADDR) |-> prdata[3:2] == 2'h0)
        else $error("reserved control bits not zero");
    a_off_reads_zero: assert property (s_done ##0 (!pwrite && array_off && paddr <= `EE_ARRAY_TOP)
        |-> prdata == 32'h00000000) else $error("array readable while off");
    a_clk_sel_cause: assert property ($changed(pump_clk_bus) |-> $past(wr_ctrl) || $past(srst))
        else $error("pump clock select changed without a write");
    a_off_cause: assert property ($changed(array_off) |-> $past(wr_ctrl) || $past(srst))
        else $error("power-down changed without a write");
    a_stop_kills_pump: assert property (stop_mode [*5] |-> !pump_on)
        else $error("pump stays on in stop mode");
endmodule : ee_ctrl_props

bind eeprom_program_erase_ctrl ee_ctrl_props i_ee_ctrl_props (.core_clk(core_clk), .srst(srst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .stop_mode(stop_mode), .pump_on(pump_on),
    .pump_clk_bus(pump_clk_bus), .array_off(array_off));

`default_nettype wire

// File: tb/cpu_model.sv
`timescale 1ns/1ns
`default_nettype none

module cpu_model (
    input wire logic core_clk, // Bus clock.
    output logic psel, // APB select.
    output logic penable, // APB access phase.
    output logic pwrite, // APB direction.
    output logic [11:0] paddr, // APB address.
    output logic [31:0] pwdata, // APB write data.
    input wire logic [31:0] prdata, // APB read data.
    input wire logic pready, // APB ready.
    input wire logic pslverr // APB error.
);
    // The bus is idle from time zero.
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h00000000;
    end

    // One transfer; the request stands until ready is seen at an edge, since the slave may stretch it.
    task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d,
                        output logic [31:0] r, output logic e);
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h000000, d};
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        pwdata <= ~pwdata; // Released data is scrambled so nothing leans on it.
    endtask : xfer
endmodule : cpu_model

`default_nettype wire

// File: tb/tb.sv
`include "eeprom_ctrl_params.svh"
`timescale 1ns/1ns
`default_nettype none

module tb;
    localparam logic [11:0] CA = `EE_CTRL_ADDR;
    localparam logic [11:0] NA = `EE_NVCFG_ADDR;
    localparam logic [11:0] VA = `EE_VCFG_ADDR;
    localparam logic [7:0] FF = `EE_ERASED_BYTE;
    typedef struct packed {
        logic w; logic [11:0] a; logic [7:0] d; logic [7:0] x; logic e;
    } row_t;
    logic core_clk = 1'b0;
    logic srst = 1'b1;
    logic stop_mode = 1'b0;
    logic psel, penable, pwrite, pready, pslverr, pump_on, pump_clk_bus, array_off, er;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    int n_mismatch = 0;
    int n_tests = 0;
    int cyc = 0;
    row_t rows [10];

    // Short pulse counts keep every operation to a handful of cycles.
    eeprom_program_erase_ctrl #(.PROGRAM_CYCLES(16'h0004), .BLOCK_CYCLES(16'h0006),
        .BULK_CYCLES(16'h0008), .RECOVERY_CYCLES(16'h0004)) i_eeprom_program_erase_ctrl (
        .core_clk(core_clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .stop_mode(stop_mode), .pump_on(pump_on), .pump_clk_bus(pump_clk_bus), .array_off(array_off));
    cpu_model i_cpu_model (.core_clk(core_clk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

    // The clock, and a ceiling that cuts a hang short.
    always #20 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_mismatch++;
            finish_test();
        end
    end

    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        n_tests++;
        if (g !== x) begin
            n_mismatch++;
            $display("[ERR] %0t got %h expected %h", $time, g, x);
        end
    endtask : chk

    task automatic chk_flag(input logic g, input logic x);
        chk({31'h0, g}, {31'h0, x});
    endtask : chk_flag

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        i_cpu_model.xfer(1'b1, a, d, rd, er);
    endtask : wr

    task automatic rdc(input logic [11:0] a, input logic [7:0] x);
        i_cpu_model.xfer(1'b0, a, 8'h00, rd, er);
        chk(rd, {24'h000000, x});
    endtask : rdc

    // One program or erase pass; p says whether voltage may be applied, s adds a stop request.
    task automatic op(input logic [1:0] m, input logic [11:0] a, input logic [7:0] d,
                      input logic p, input logic s);
        int i;
        wr(CA, {2'b00, m, 4'h2});
        if (a < CA) begin
            wr(a + 12'h004, 8'hC3);
        end
        wr(a, d);
        if (a < CA) begin
            rdc(a + 12'h008, d);
        end
        wr(CA, {2'b00, m, 4'h3});
        repeat (2) @(posedge core_clk);
        chk_flag(pump_on, p);
        if (p) begin
            wr(CA, {2'b00, ~m, 4'h3});
            rdc(CA, {2'b00, m, 4'h3});
        end
        if (s) begin
            stop_mode <= 1'b1;
            repeat (8) @(posedge core_clk);
            chk_flag(pump_on, 1'b0);
            rdc(CA, {2'b00, m, 4'h3});
            stop_mode <= 1'b0;
        end
        for (i = 0; i < 20; i++) begin
            i_cpu_model.xfer(1'b0, `EE_STATUS_ADDR, 8'h00, rd, er);
            if (rd[2] === 1'b1) break;
        end
        chk(rd & 32'h00000004, p ? 32'h00000004 : 32'h00000000);
        wr(CA, 8'h00);
        if (p) begin
            rdc(CA, {2'b00, m, 4'h2});
        end
        wr(CA, 8'h00);
        rdc(CA, 8'h00);
    endtask : op

    task automatic finish_test();
        $display("tests %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : finish_test

    // Plain register cases first, then the program and erase sequences.
    initial begin
        rows[0] = '{1'b0, CA, 8'h00, `EE_CTRL_RESET, 1'b0};
        rows[1] = '{1'b0, NA, 8'h00, `EE_NV_FACTORY, 1'b0};
        rows[2] = '{1'b0, VA, 8'h00, `EE_NV_FACTORY, 1'b0};
        rows[3] = '{1'b0, 12'h014, 8'h00, FF, 1'b0};
        rows[4] = '{1'b1, 12'h810, 8'h5A, 8'h00, 1'b1};
        rows[5] = '{1'b1, CA, 8'h80, 8'h00, 1'b0};
        rows[6] = '{1'b0, CA, 8'h00, 8'h80, 1'b0};
        rows[7] = '{1'b1, CA, 8'h40, 8'h00, 1'b0};
        rows[8] = '{1'b0, 12'h014, 8'h00, 8'h00, 1'b0};
        rows[9] = '{1'b1, CA, 8'h00, 8'h00, 1'b0};
        repeat (10) @(posedge core_clk);
        srst <= 1'b0;
        foreach (rows[k]) begin
            i_cpu_model.xfer(rows[k].w, rows[k].a, rows[k].d, rd, er);
            chk_flag(er, rows[k].e);
            if (!rows[k].w) chk(rd, {24'h000000, rows[k].x});
            if (k == 6) chk_flag(pump_clk_bus, 1'b1);
            if (k == 8) chk_flag(array_off, 1'b1);
        end
        repeat (10) @(posedge core_clk);
        wr(CA, 8'h01);
        rdc(CA, 8'h00);
        wr(CA, 8'h02);
        wr(CA, 8'h12);
        rdc(CA, 8'h02);
        op(2'b00, 12'h00C, 8'h5A, 1'b1, 1'b1);
        rdc(12'h00C, 8'h5A);
        rdc(12'h010, FF);
        op(2'b01, 12'h00C, 8'h00, 1'b1, 1'b0);
        rdc(12'h00C, FF);
        op(2'b00, 12'h208, 8'h00, 1'b1, 1'b0);
        op(2'b10, 12'h204, 8'h00, 1'b1, 1'b0);
        rdc(12'h208, FF);
        rdc(NA, `EE_NV_FACTORY);
        op(2'b01, NA, 8'h00, 1'b1, 1'b0);
        op(2'b00, NA, 8'h11, 1'b1, 1'b0);
        rdc(VA, `EE_NV_FACTORY);
        rdc(NA, 8'h11);
        rdc(VA, 8'h11);
        op(2'b00, 12'h000, 8'h00, 1'b0, 1'b0);
        rdc(12'h000, FF);
        op(2'b11, 12'h600, 8'h00, 1'b0, 1'b0);
        srst <= 1'b1;
        repeat (2) @(posedge core_clk);
        srst <= 1'b0;
        rdc(CA, `EE_CTRL_RESET);
        rdc(VA, 8'h11);
        finish_test();
    end
endmodule : tb

`default_nettype wire
